// File: adcs_mod_model.sv
/*
  Stand-in for the analog modulator that feeds the conversion sequencer.
  Assumes chop_polarity comes from the sequencer on sys_clk.
*/
`timescale 1ns/1ps
module adcs_mod_model (
  // Clock and chopping
  input wire logic sys_clk,
  input wire logic chop_polarity,
  // Input kind: 0 above full scale, 1 below, 2 amplifier offset only
  input wire logic [1:0] mode,
  // Bit stream
  output logic mod_bit
);
  // ==========================================================================
  // Stream
  // Chopping turns the input round, so the stream follows it; an offset does
  // not turn, and only cancels when the sequencer mirrors it digitally
  always @(negedge sys_clk) begin
    mod_bit <= (mode == 2'h2) ? 1'b1 : ((mode == 2'h0) ^ chop_polarity);
  end
endmodule

// File: adcs_pkg.sv
/*
  Types shared by the conversion sequencer files.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package adcs_pkg;
  typedef logic [15:0] adcs_word_t;
  typedef logic [4:0] adcs_res_t;
  typedef logic [1:0] adcs_sel2_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ELEM = 2'b01,
    ST_FINAL = 2'b10
  } adcs_state_e;
endpackage

// File: adcs_rate_div.sv
/*
  Sample-rate divider: one-cycle tick per sampling period.
  Assumes a 40 MHz system clock; the rate code is stable during a conversion.
*/
`timescale 1ns/1ps
`include "adcs_regs.svh"
module adcs_rate_div (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Tick carrier
  adcs_tick_if.gen tk
);
  import adcs_pkg::*;

  logic [9:0] cnt_reg;
  logic [9:0] period_m1;
  logic tick_reg;

  // ==========================================================================
  // Period: base 500 kHz period doubled per step below code 3
  assign period_m1 = 10'((`ADCS_TICK_BASE_CYC << (`ADCS_RATE_CODE_MAX - tk.rate_sel)) - 1); // RULE16

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= 10'h000;
      tick_reg <= 1'b0;
    end else if (cnt_reg >= period_m1) begin
      cnt_reg <= 10'h000;
      tick_reg <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 10'h001;
      tick_reg <= 1'b0;
    end
  end

  assign tk.tick = tick_reg;
endmodule

// File: adcs_regs.svh
/*
  Constants for the conversion sequencer: clock rates, sample-rate divider,
  oversampling and result-format figures.
  Assumes inclusion by bare name; definitions only.
*/
`ifndef ADCS_REGS_SVH
`define ADCS_REGS_SVH

// ==========================================================================
// Clocking
`define ADCS_SYS_CLK_KHZ 40000
`define ADCS_OSC_KHZ 4000
`define ADCS_FS_MAX_KHZ 500
// System cycles per sample period at the fastest rate (code 3)
`define ADCS_TICK_BASE_CYC (`ADCS_SYS_CLK_KHZ / `ADCS_FS_MAX_KHZ)
`define ADCS_RATE_CODE_MAX 2'h3

// ==========================================================================
// Conversion format
`define ADCS_OSR_EXP_BASE 4'h3
`define ADCS_RESULT_MSB 15
`define ADCS_RES_FULL 5'h10
`define ADCS_WORD_POS_MAX 16'h7fff
`define ADCS_WORD_NEG_MIN 16'h8000

// ==========================================================================
// Bias field codes and the highest rate code each allows
`define ADCS_BIAS_QUARTER 2'h0
`define ADCS_BIAS_HALF 2'h1
`define ADCS_RATE_LIM_QUARTER 2'h1
`define ADCS_RATE_LIM_HALF 2'h2

`endif

// File: adcs_sequencer.sv
/*
  Conversion sequencer of an incremental oversampling converter: sequencing
  of elementary conversions with offset chopping, continuous or on-request
  operation, and formatting of the saturated 16-bit result.
  Assumes config and start inputs come from logic on sys_clk; mod_bit comes
  from the analog modulator and is asynchronous.
*/
`timescale 1ns/1ps
`include "adcs_regs.svh"
// What the document requires of this block
// (RULE1) Count field 00/01/10/11 gives 1/2/4/8 elementary conversions.
// (RULE2) Software programs two or more elementary conversions for offset cancellation.
// (RULE3) Resolution equals twice log2 ratio plus log2 elementary count.
// (RULE4) Reported resolution is capped at sixteen bits.
// (RULE5) Conversion lasts count times (ratio plus one), plus one, sampling periods.
// (RULE6) One input bit selects continuous or on-request operation.
// (RULE7) Continuous mode restarts at once, writes the result, pulses completion.
// (RULE8) On-request mode starts on the start bit, same sequencing and duration.
// (RULE9) Result is a signed sixteen-bit two's complement word.
// (RULE10) Out-of-range results clamp to 0x7fff or 0x8000.
// (RULE11) Below sixteen bits, top unused bit is one, lower unused bits zero.
// (RULE12) Result also readable as separate high and low bytes.
// (RULE13) Bias codes 00/01/11 allow sampling up to 125/250/500 kHz.
// (RULE14) Software disables converter and amplifiers when idle.
// (RULE15) Start bit or default-start bit each begin a conversion.
// (RULE16) Rate field selects 62.5, 125, 250 or 500 kHz from 4 MHz; the divider derives them from the 40 MHz system clock.
// (RULE17) Ratio field gives two to the power three plus field, 8 to 1024.
// (RULE18) Elementary conversions alternate offset polarity; result is their mean.
// (RULE19) On-request mode returns to idle after writing the result.
module adcs_sequencer (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Configuration
  input wire logic [2:0] oversample_ratio_sel,
  input wire adcs_pkg::adcs_sel2_t elem_conv_count_sel,
  input wire adcs_pkg::adcs_sel2_t sample_rate_sel,
  input wire logic continuous_mode,
  input wire logic start_req,
  input wire logic default_start_req,
  input wire adcs_pkg::adcs_sel2_t converter_bias_sel,
  input wire adcs_pkg::adcs_sel2_t amplifier_bias_sel,
  // Modulator
  input wire logic mod_bit,
  output logic chop_polarity,
  // Result and status
  output adcs_pkg::adcs_word_t conversion_result_word,
  output logic [7:0] result_high_byte,
  output logic [7:0] result_low_byte,
  output adcs_pkg::adcs_res_t resolution_bits,
  output logic conv_done_pulse,
  output logic conv_busy,
  output adcs_pkg::adcs_sel2_t converter_bias_out,
  output adcs_pkg::adcs_sel2_t amplifier_bias_out,
  output logic bias_rate_error
);
  import adcs_pkg::*;

  adcs_tick_if tk ();
  adcs_state_e state_reg;
  logic [3:0] osr_exp_reg;
  logic [1:0] nel_exp_reg;
  logic [10:0] period_cnt_reg;
  logic [2:0] elem_cnt_reg;
  logic signed [15:0] acc_reg;
  logic mod_meta_reg;
  logic mod_sync_reg;
  logic [13:0] tick_cnt_reg;
  logic start_any;
  logic begin_conv;
  logic restart;
  logic final_tick;
  logic elem_end;
  logic [10:0] osr_val;
  logic [2:0] nel_last;
  adcs_res_t res_next;
  adcs_word_t word_next;

  // ==========================================================================
  // Sample-rate divider
  assign tk.rate_sel = sample_rate_sel;

  adcs_rate_div u_div (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .tk(tk)
  );

  // ==========================================================================
  // Modulator bit synchroniser
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mod_meta_reg <= 1'b0;
      mod_sync_reg <= 1'b0;
    end else begin
      mod_meta_reg <= mod_bit;
      mod_sync_reg <= mod_meta_reg;
    end
  end

  // ==========================================================================
  // Sequencing
  assign start_any = start_req | default_start_req; // RULE15
  assign begin_conv = (state_reg == ST_IDLE) && start_any; // RULE8
  assign final_tick = (state_reg == ST_FINAL) && tk.tick;
  assign restart = final_tick && continuous_mode; // RULE6 RULE7
  assign osr_val = 11'h001 << osr_exp_reg; // RULE17
  assign nel_last = 3'((4'h1 << nel_exp_reg) - 4'h1); // RULE1
  assign elem_end = (state_reg == ST_ELEM) && tk.tick && (period_cnt_reg == osr_val); // RULE5

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (begin_conv) begin
            state_reg <= ST_ELEM;
          end
        end
        ST_ELEM: begin
          if (elem_end && elem_cnt_reg == nel_last) begin
            state_reg <= ST_FINAL;
          end
        end
        ST_FINAL: begin
          if (tk.tick) begin
            state_reg <= continuous_mode ? ST_ELEM : ST_IDLE; // RULE7 RULE19
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Settings are latched per conversion so a mid-conversion write cannot
  // split one result across two ratios.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      osr_exp_reg <= `ADCS_OSR_EXP_BASE;
      nel_exp_reg <= 2'h0;
    end else if (begin_conv || restart) begin
      osr_exp_reg <= `ADCS_OSR_EXP_BASE + {1'b0, oversample_ratio_sel}; // RULE17
      nel_exp_reg <= elem_conv_count_sel; // RULE1
    end
  end

  // The first period of each elementary conversion resets the integrator
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      period_cnt_reg <= 11'h000;
      elem_cnt_reg <= 3'h0;
      tick_cnt_reg <= 14'h0000;
    end else if (begin_conv || restart) begin
      period_cnt_reg <= 11'h000;
      elem_cnt_reg <= 3'h0;
      tick_cnt_reg <= 14'h0000;
    end else if (tk.tick && state_reg != ST_IDLE) begin
      tick_cnt_reg <= tick_cnt_reg + 14'h0001;
      if (elem_end) begin
        period_cnt_reg <= 11'h000;
        elem_cnt_reg <= elem_cnt_reg + 3'h1;
      end else if (state_reg == ST_ELEM) begin
        period_cnt_reg <= period_cnt_reg + 11'h001;
      end
    end
  end

  // Odd elementary conversions see the input reversed, so their sign flips
  assign chop_polarity = elem_cnt_reg[0]; // RULE18

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_reg <= 16'sh0000;
    end else if (begin_conv || restart) begin
      acc_reg <= 16'sh0000;
    end else if (state_reg == ST_ELEM && tk.tick && period_cnt_reg != 11'h000) begin
      acc_reg <= (mod_sync_reg ^ elem_cnt_reg[0]) ? acc_reg + 16'sh0001 : acc_reg - 16'sh0001; // RULE18
    end
  end

  // ==========================================================================
  // Result formatting
  always_comb begin
    logic [5:0] res_raw;
    logic [3:0] shift;
    logic signed [31:0] scaled;
    logic [15:0] keep;
    keep = 16'hffff;
    res_raw = {1'b0, osr_exp_reg, 1'b0} + {4'h0, nel_exp_reg}; // RULE3
    res_next = (res_raw > 6'(`ADCS_RES_FULL)) ? `ADCS_RES_FULL : 5'(res_raw); // RULE4
    // Sum over N*OSR samples is the mean scaled to full 16-bit span
    shift = 4'(`ADCS_RESULT_MSB) - osr_exp_reg - {2'h0, nel_exp_reg}; // RULE18
    scaled = 32'(acc_reg) <<< shift;
    if (scaled > 32'sh00007fff) begin
      word_next = `ADCS_WORD_POS_MAX; // RULE10
    end else if (scaled < -32'sh00008000) begin
      word_next = `ADCS_WORD_NEG_MIN; // RULE10
    end else begin
      word_next = scaled[15:0]; // RULE9
    end
    if (res_next < `ADCS_RES_FULL) begin
      keep = 16'hffff << (5'h10 - res_next);
      word_next = (word_next & keep) | (16'h8000 >> res_next); // RULE11
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      conversion_result_word <= 16'h0000;
      result_high_byte <= 8'h00;
      result_low_byte <= 8'h00;
      resolution_bits <= 5'h00;
      conv_done_pulse <= 1'b0;
    end else begin
      conv_done_pulse <= final_tick; // RULE7
      if (final_tick) begin
        conversion_result_word <= word_next;
        result_high_byte <= word_next[15:8]; // RULE12
        result_low_byte <= word_next[7:0]; // RULE12
        resolution_bits <= res_next; // RULE3
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      conv_busy <= 1'b0;
    end else if (begin_conv) begin
      conv_busy <= 1'b1;
    end else if (final_tick && !continuous_mode) begin
      conv_busy <= 1'b0; // RULE19
    end
  end

  // ==========================================================================
  // Bias settings and allowed sampling rate; unlisted code 10 is taken as quarter
  function automatic logic [1:0] rate_lim(input logic [1:0] b);
    if (b == `ADCS_BIAS_QUARTER || b == 2'h2) begin
      rate_lim = `ADCS_RATE_LIM_QUARTER;
    end else if (b == `ADCS_BIAS_HALF) begin
      rate_lim = `ADCS_RATE_LIM_HALF;
    end else begin
      rate_lim = `ADCS_RATE_CODE_MAX;
    end
  endfunction

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      converter_bias_out <= 2'h3;
      amplifier_bias_out <= 2'h3;
      bias_rate_error <= 1'b0;
    end else begin
      converter_bias_out <= converter_bias_sel;
      amplifier_bias_out <= amplifier_bias_sel;
      bias_rate_error <= (sample_rate_sel > rate_lim(converter_bias_sel)) ||
                         (sample_rate_sel > rate_lim(amplifier_bias_sel)); // RULE13
    end
  end

  // ==========================================================================
  // Assertions
  sequence s_idle_start;
    state_reg == ST_IDLE && start_any;
  endsequence
  sequence s_last_tick;
    state_reg == ST_FINAL && tk.tick;
  endsequence

  AST_START_BEGINS: assert property (@(posedge sys_clk) disable iff (!arst_n) // RULE15
    s_idle_start |=> conv_busy && state_reg == ST_ELEM)
    else $error("start request did not begin a conversion");
  AST_CONV_LENGTH: assert property (@(posedge sys_clk) disable iff (!arst_n) // RULE5
    s_last_tick |-> (tick_cnt_reg + 14'h0001) == 14'(((14'h1 << nel_exp_reg) * ({3'h0, osr_val} + 14'h1)) + 14'h1))
    else $error("conversion length in sample periods is wrong");
  AST_CONT_RESTART: assert property (@(posedge sys_clk) disable iff (!arst_n) // RULE7
    s_last_tick ##0 continuous_mode |=> conv_done_pulse && state_reg == ST_ELEM && conv_busy)
    else $error("continuous mode did not restart with a completion pulse");
  AST_REQ_IDLE: assert property (@(posedge sys_clk) disable iff (!arst_n) // RULE19
    s_last_tick ##0 !continuous_mode |=> state_reg == ST_IDLE && !conv_busy && conv_done_pulse)
    else $error("on-request conversion did not return to idle");
  // A restart latches the next settings on the same edge, so compare with the finished ones
  AST_RES_VALUE: assert property (@(posedge sys_clk) disable iff (!arst_n) // RULE4
    conv_done_pulse |-> resolution_bits <= 5'h10 && resolution_bits >= 5'h06 && (resolution_bits == 5'h10 ||
      resolution_bits == {$past(osr_exp_reg), 1'b0} + {3'h0, $past(nel_exp_reg)}))
    else $error("reported resolution out of range");
  AST_FORCED_BITS: assert property (@(posedge sys_clk) disable iff (!arst_n) // RULE11
    conv_done_pulse && resolution_bits < 5'h10 |->
      ((conversion_result_word & ~(16'hffff << (5'h10 - resolution_bits))) == (16'h8000 >> resolution_bits)))
    else $error("unused low bits not forced to one then zeros");
  AST_BYTES_SPLIT: assert property (@(posedge sys_clk) disable iff (!arst_n) // RULE12
    conv_done_pulse |-> {result_high_byte, result_low_byte} == conversion_result_word)
    else $error("byte registers disagree with result word");
  AST_CHOP_TOGGLE: assert property (@(posedge sys_clk) disable iff (!arst_n) // RULE18
    elem_end && state_reg == ST_ELEM && elem_cnt_reg != nel_last |=> chop_polarity != $past(chop_polarity))
    else $error("offset polarity did not alternate");
  AST_BIAS_LIMIT: assert property (@(posedge sys_clk) disable iff (!arst_n) // RULE13
    converter_bias_sel == 2'h0 && sample_rate_sel == 2'h3 |=> bias_rate_error)
    else $error("rate above quarter-bias limit not flagged");
  AST_IDLE_HOLD: assert property (@(posedge sys_clk) disable iff (!arst_n) // RULE8
    state_reg == ST_IDLE && !start_any |=> state_reg == ST_IDLE)
    else $error("conversion began without a start request");
endmodule

// File: adcs_sequencer_tb.sv
/*
  Self-checking bench for the conversion sequencer.
  Assumes adcs_pkg and the modulator stand-in are compiled first.
*/
`timescale 1ns/1ps
module adcs_sequencer_tb;
  import adcs_pkg::*;
  logic sys_clk, arst_n, continuous_mode, start_req, default_start_req;
  logic [2:0] osr_sel;
  adcs_sel2_t nel_sel, rate_sel, cbias, abias, cb_out, ab_out;
  logic [1:0] mod_mode;
  logic mod_bit, chop, done, busy, rerr;
  adcs_word_t word;
  logic [7:0] hi, lo;
  adcs_res_t res;
  logic [8:0] cases [7] = '{9'h003, 9'h016, 9'h02b, 9'h033, 9'h05b, 9'h097, 9'h143};
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  integer seed = 32'h76a74424;

  adcs_sequencer i_dut (.sys_clk(sys_clk), .arst_n(arst_n), .oversample_ratio_sel(osr_sel),
    .elem_conv_count_sel(nel_sel), .sample_rate_sel(rate_sel), .continuous_mode(continuous_mode),
    .start_req(start_req), .default_start_req(default_start_req), .converter_bias_sel(cbias),
    .amplifier_bias_sel(abias), .mod_bit(mod_bit), .chop_polarity(chop), .conversion_result_word(word),
    .result_high_byte(hi), .result_low_byte(lo), .resolution_bits(res), .conv_done_pulse(done),
    .conv_busy(busy), .converter_bias_out(cb_out), .amplifier_bias_out(ab_out), .bias_rate_error(rerr));
  adcs_mod_model i_mod (.sys_clk(sys_clk), .chop_polarity(chop), .mode(mod_mode), .mod_bit(mod_bit));

  // ==========================================================================
  // Clock and hang guard
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 110000) begin
      mismatches++;
      final_report();
    end
  end

  // ==========================================================================
  // Checking and expectations
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  function automatic int ticks(input logic [2:0] o, input logic [1:0] n);
    return (1 << n) * ((8 << o) + 1) + 1;
  endfunction
  function automatic logic [4:0] exp_res(input logic [2:0] o, input logic [1:0] n);
    int v;
    v = 2 * (3 + o) + n;
    return (v > 16) ? 5'h10 : 5'(v);
  endfunction
  function automatic logic [15:0] exp_word(input logic [2:0] o, input logic [1:0] n, input logic [1:0] m);
    logic [15:0] w;
    logic [4:0] r;
    r = exp_res(o, n);
    w = (m == 2'h1) ? 16'h8000 : (m == 2'h2 && n != 2'h0) ? 16'h0000 : 16'h7fff;
    if (r < 5'h10)
      w = (w & ~((16'h1 << (16 - r)) - 16'h1)) | (16'h1 << (15 - r));
    return w;
  endfunction
  function automatic logic [1:0] lim(input logic [1:0] b);
    return (b == 2'h3) ? 2'h3 : (b == 2'h1) ? 2'h2 : 2'h1;
  endfunction

  // ==========================================================================
  // Stimulus
  task automatic wait_done(output int n);
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (done !== 1'b1 && n < 30000);
    if (n >= 30000) begin
      mismatches++;
      final_report();
    end
  endtask
  task automatic run_req(input logic [2:0] o, input logic [1:0] n, input logic [1:0] m,
                         input logic [1:0] r, input bit dflt);
    int c, t, p;
    @(posedge sys_clk);
    osr_sel <= o;
    nel_sel <= n;
    mod_mode <= m;
    rate_sel <= r;
    if (dflt) default_start_req <= 1'b1;
    else start_req <= 1'b1;
    @(posedge sys_clk);
    start_req <= 1'b0;
    default_start_req <= 1'b0;
    wait_done(c);
    t = ticks(o, n);
    p = 640 >> r;
    check(32'(c >= (t - 1) * p + 2 && c <= t * p + 3), 32'h1, "duration");
    check(word, exp_word(o, n, m), "result word");
    check({hi, lo}, exp_word(o, n, m), "result bytes");
    check(res, exp_res(o, n), "resolution");
    repeat (p) @(negedge sys_clk);
    check({done, busy}, 2'h0, "idle after result");
    $display("test on-request osr %0d count %0d done", o, n);
  endtask

  initial begin
    arst_n = 1'b0;
    continuous_mode = 1'b0;
    start_req = 1'b0;
    default_start_req = 1'b0;
    osr_sel = 3'h0;
    nel_sel = 2'h0;
    rate_sel = 2'h3;
    cbias = 2'h3;
    abias = 2'h3;
    mod_mode = 2'h0;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    check({word, res, busy, done, rerr, cb_out, ab_out}, {21'h0, 3'h0, 4'hf}, "reset values");
    @(posedge sys_clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      @(posedge sys_clk);
      cbias <= 2'(i >> 2);
      abias <= 2'(i);
      rate_sel <= (i == 0) ? 2'h3 : 2'($random(seed));
      @(posedge sys_clk);
      @(negedge sys_clk);
      check(rerr, 1'(rate_sel > lim(cbias) || rate_sel > lim(abias)), "rate flag");
      check({cb_out, ab_out}, {cbias, abias}, "bias copies");
    end
    $display("test bias limits done");
    // Full bias keeps every rate legal for the conversions below
    @(posedge sys_clk);
    cbias <= 2'h3;
    abias <= 2'h3;
    for (int i = 0; i < 7; i++)
      run_req(cases[i][8:6], cases[i][5:4], cases[i][3:2], cases[i][1:0], i[0]);
    for (int i = 0; i < 4; i++)
      // Count kept below eight here so the random runs stay inside the cycle budget
      run_req(3'($random(seed) & 1), 2'($unsigned($random(seed)) % 3), 2'($unsigned($random(seed)) % 3),
              2'h3, i[0]);
    for (int r = 0; r < 4; r++) begin
      int c;
      @(posedge sys_clk);
      osr_sel <= 3'h0;
      nel_sel <= 2'h0;
      rate_sel <= 2'(r);
      mod_mode <= 2'(r % 3);
      continuous_mode <= 1'b1;
      start_req <= 1'b1;
      @(posedge sys_clk);
      start_req <= 1'b0;
      wait_done(c);
      wait_done(c);
      check(c, 10 * (640 >> r), "restart spacing");
      check(word, exp_word(3'h0, 2'h0, 2'(r % 3)), "continuous word");
      check(busy, 1'b1, "busy between conversions");
      check(chop, 1'b0, "chop back to first elementary");
      @(posedge sys_clk);
      continuous_mode <= 1'b0;
      wait_done(c);
      @(negedge sys_clk);
      check({done, busy}, 2'h0, "stops after mode drop");
      $display("test continuous rate %0d done", r);
    end
    // Idle: bias turned down to the lowest setting while nothing converts
    @(posedge sys_clk);
    cbias <= 2'h0;
    abias <= 2'h0;
    @(posedge sys_clk);
    @(negedge sys_clk);
    check({cb_out, ab_out, busy}, 5'h00, "idle low bias");
    check(rerr, 1'b1, "idle low bias flags fast rate");
    $display("test idle bias done");
    final_report();
  end
endmodule

// File: adcs_tick_if.sv
/*
  Carrier between the sequencer and its sample-rate divider.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ps
interface adcs_tick_if;
  logic [1:0] rate_sel;
  logic tick;
  modport gen (input rate_sel, output tick);
  modport use_side (output rate_sel, input tick);
endinterface
